//--- core/eprom_prog_defs.svh
// Constants for the EPROM programming sequencer: timing figures, cycle counts and limits.
// Assumes a 100 MHz system clock; included by bare name from the package and the sequencer.
// Notes on behaviour
// - Each program pulse holds chip enable low 100 us, within 95 to 105 us.
// - A run starts with the lowest array address on the address lines.
// - Core supply goes to 6.5V and programming supply to 13.0V before pulsing.
// - Each address first gets one pulse with a verify read, then the verify loop.
// - On mismatch apply up to 10 more pulses, each followed by a verify read.
// - Still mismatching after 10 retry pulses aborts and flags the device failed.
// - A verified byte advances to the next address until all are handled.
// - After the last address drop supplies to 5.0V and read back every byte.
// - Wait 150 ns for data after output enable falls, 130 ns float after rise.
// - Core supply rises no later and falls no earlier than programming supply.
// - Identification readout holds the id-mode pin at 11.5 to 12.5 volts.
// - In identification mode all address inputs but addr[0] are held low.
`ifndef EPROM_PROG_DEFS_SVH
`define EPROM_PROG_DEFS_SVH
`define CLK_MHZ 100
`define PULSE_NOM_US 100
`define PULSE_CYCLES (`PULSE_NOM_US * `CLK_MHZ)
`define SETUP_US 2
`define SETUP_CYCLES (`SETUP_US * `CLK_MHZ)
`define OUT_VALID_NS 150
`define OUT_VALID_CYCLES ((`OUT_VALID_NS * `CLK_MHZ + 999) / 1000)
`define OUT_FLOAT_NS 130
`define OUT_FLOAT_CYCLES ((`OUT_FLOAT_NS * `CLK_MHZ + 999) / 1000)
`define RETRY_LIMIT 10
`define ADDR_WIDTH 15
`define DATA_WIDTH 8
`define FIFO_DEPTH 16
`endif

//--- core/eprom_prog_pkg.sv
// Types shared by the EPROM programming sequencer.
// Assumes the defs header is on the include path.
`include "eprom_prog_defs.svh"
package eprom_prog_pkg;
   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_power_up = 4'b0001,
      st_pulse = 4'b0010,
      st_recover = 4'b0011,
      st_verify_wait = 4'b0100,
      st_verify_float = 4'b0101,
      st_power_down = 4'b0110,
      st_check_read = 4'b0111,
      st_check_float = 4'b1000,
      st_id_read = 4'b1001,
      st_id_float = 4'b1010,
      st_done = 4'b1011
   } seq_state_e;
endpackage : eprom_prog_pkg

//--- core/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Filling side.
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side.
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_s;
   fifo_s st;
   fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = mem[st.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update.
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_st.count = st.count + 1'b1;
      end else if (pop && !push) begin
         next_st.count = st.count - 1'b1;
      end
   end

   // State register and storage write.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
      if (push) begin
         mem[st.wr_ptr] <= in_data;
      end
   end
endmodule : byte_fifo
`default_nettype wire

//--- core/eprom_programmer.sv
// Programmer for a 32K x 8 UV EPROM: rapid program algorithm, final check and id readout.
// Assumes external switches turn the supply-select outputs into the real voltages, and
// that source data arrives as a byte stream in address order, one byte per location for programming and again for the final check.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_prog_defs.svh"
module eprom_programmer #(
   parameter int ADDR_WIDTH = `ADDR_WIDTH,
   parameter int DATA_WIDTH = `DATA_WIDTH,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int PULSE_CYCLES = `PULSE_CYCLES,
   parameter int SETUP_CYCLES = `SETUP_CYCLES,
   parameter int RETRY_LIMIT = `RETRY_LIMIT,
   parameter logic [ADDR_WIDTH-1:0] LAST_ADDR = '1
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Commands.
   input wire logic start_program,
   input wire logic start_id,
   // Source data stream.
   input wire logic src_valid,
   input wire logic [DATA_WIDTH-1:0] src_data,
   output logic src_ready,
   // Status.
   output logic busy,
   output logic done,
   output logic failed,
   output logic [ADDR_WIDTH-1:0] fail_addr,
   output logic [DATA_WIDTH-1:0] maker_code,
   output logic [DATA_WIDTH-1:0] part_code,
   // Device pins.
   output logic [ADDR_WIDTH-1:0] addr,
   output logic id_mode_pin,
   output logic chip_enable_n,
   output logic output_enable_n,
   output logic [DATA_WIDTH-1:0] data_out,
   output logic data_oe_n,
   input wire logic [DATA_WIDTH-1:0] data_in,
   output logic vcc_prog,
   output logic vpp_prog
);
   localparam int CW = 16;
   localparam int RW = $clog2(RETRY_LIMIT + 1);
   localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);
   localparam logic [CW-1:0] SETUP_LAST = CW'(SETUP_CYCLES - 1);
   // Data may arrive as late as the full valid delay; it must then sit in sync stages two and three.
   localparam logic [CW-1:0] VALID_LAST = CW'(`OUT_VALID_CYCLES + 4);
   localparam logic [CW-1:0] FLOAT_LAST = CW'(`OUT_FLOAT_CYCLES - 1);
   // Reads that lower both enables together wait for the longer of setup and valid delay.
   localparam logic [CW-1:0] READ_LAST = (SETUP_LAST > VALID_LAST) ? SETUP_LAST : VALID_LAST;

   typedef struct packed {
      eprom_prog_pkg::seq_state_e state;
      logic [CW-1:0] timer;
      logic [RW-1:0] retries;
      logic check_pass;
      logic first_pulse;
      logic matched;
      logic [DATA_WIDTH-1:0] target;
      logic [ADDR_WIDTH-1:0] addr;
      logic id_mode_pin;
      logic ce_n;
      logic oe_n;
      logic data_oe_n;
      logic vcc_prog;
      logic vpp_prog;
      logic busy;
      logic done;
      logic failed;
      logic [ADDR_WIDTH-1:0] fail_addr;
      logic [DATA_WIDTH-1:0] maker_code;
      logic [DATA_WIDTH-1:0] part_code;
      logic [3*DATA_WIDTH-1:0] rd_sync;
   } prog_s;

   prog_s st;
   prog_s next_st;
   logic fifo_valid;
   logic [DATA_WIDTH-1:0] fifo_data;
   logic fifo_take;
   logic [DATA_WIDTH-1:0] rd_byte;
   logic rd_stable;

   // Source data is buffered so the feeder can run ahead of the slow pulses.
   byte_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(src_valid),
      .in_data(src_data),
      .in_ready(src_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_take)
   );

   // Read data crosses from the pins; a verify or check byte counts once stages two and three agree.
   assign rd_byte = st.rd_sync[3*DATA_WIDTH-1 -: DATA_WIDTH];
   assign rd_stable = (rd_byte == st.rd_sync[2*DATA_WIDTH-1 -: DATA_WIDTH]);

   // A byte is popped when a new address is loaded, in program or check phase, and also at the end of power down after an abort.
   always_comb begin
      fifo_take = 1'b0;
      if ((st.state == eprom_prog_pkg::st_power_up && st.timer == SETUP_LAST) ||
          (st.state == eprom_prog_pkg::st_verify_float && st.timer == FLOAT_LAST && st.matched &&
           st.addr != LAST_ADDR) ||
          (st.state == eprom_prog_pkg::st_power_down && st.timer == SETUP_LAST) ||
          (st.state == eprom_prog_pkg::st_check_float && st.timer == FLOAT_LAST &&
           st.addr != LAST_ADDR)) begin
         fifo_take = fifo_valid;
      end
   end

   // Sequencer next-state logic.
   always_comb begin
      next_st = st;
      next_st.rd_sync = {st.rd_sync[2*DATA_WIDTH-1:0], data_in};
      next_st.timer = st.timer + 1'b1;
      case (st.state)
         eprom_prog_pkg::st_idle: begin
            next_st.timer = '0;
            if (start_program) begin
               next_st.state = eprom_prog_pkg::st_power_up;
               next_st.busy = 1'b1;
               next_st.done = 1'b0;
               next_st.failed = 1'b0;
               next_st.addr = '0;
               next_st.vcc_prog = 1'b1;
            end else if (start_id) begin
               next_st.state = eprom_prog_pkg::st_id_read;
               next_st.busy = 1'b1;
               next_st.done = 1'b0;
               next_st.addr = '0;
               next_st.id_mode_pin = 1'b1;
               next_st.oe_n = 1'b0;
               next_st.ce_n = 1'b0;
            end
         end
         eprom_prog_pkg::st_power_up: begin
            // Core supply leads the programming supply by one setup interval.
            if (st.timer == SETUP_LAST) begin
               next_st.vpp_prog = 1'b1;
            end
            if (st.timer == SETUP_LAST && !fifo_valid) begin
               next_st.timer = st.timer; // Wait here for source data.
            end else if (st.timer == SETUP_LAST) begin
               next_st.target = fifo_data;
               next_st.data_oe_n = 1'b0;
               next_st.retries = '0;
               next_st.first_pulse = 1'b1;
               next_st.state = eprom_prog_pkg::st_recover;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_recover: begin
            // Address, data and programming supply settle before each pulse.
            if (st.timer == SETUP_LAST) begin
               next_st.ce_n = 1'b0;
               next_st.state = eprom_prog_pkg::st_pulse;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_pulse: begin
            if (st.timer == PULSE_LAST) begin
               next_st.ce_n = 1'b1;
               next_st.data_oe_n = 1'b1;
               next_st.state = eprom_prog_pkg::st_verify_wait;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_verify_wait: begin
            if (st.timer == SETUP_LAST) begin
               next_st.oe_n = 1'b0;
            end
            if (st.timer == SETUP_LAST + VALID_LAST) begin
               next_st.matched = rd_stable && (rd_byte == st.target);
               next_st.oe_n = 1'b1;
               next_st.state = eprom_prog_pkg::st_verify_float;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_verify_float: begin
            if (st.timer == FLOAT_LAST) begin
               next_st.timer = '0;
               next_st.first_pulse = 1'b0;
               if (!st.matched && st.retries == RW'(RETRY_LIMIT)) begin
                  next_st.failed = 1'b1;
                  next_st.fail_addr = st.addr;
                  next_st.state = eprom_prog_pkg::st_power_down;
               end else if (!st.matched) begin
                  next_st.retries = st.retries + 1'b1;
                  next_st.data_oe_n = 1'b0;
                  next_st.state = eprom_prog_pkg::st_recover;
               end else if (st.addr == LAST_ADDR) begin
                  next_st.addr = '0;
                  next_st.state = eprom_prog_pkg::st_power_down;
               end else if (fifo_valid) begin
                  next_st.addr = st.addr + 1'b1;
                  next_st.target = fifo_data;
                  next_st.retries = '0;
                  next_st.first_pulse = 1'b1;
                  next_st.data_oe_n = 1'b0;
                  next_st.state = eprom_prog_pkg::st_recover;
               end else begin
                  next_st.timer = st.timer;
               end
            end
         end
         eprom_prog_pkg::st_power_down: begin
            // Programming supply falls first, core supply one interval later.
            next_st.vpp_prog = 1'b0;
            if (st.timer == SETUP_LAST) begin
               next_st.vcc_prog = 1'b0;
               next_st.timer = '0;
               if (st.failed) begin
                  next_st.state = eprom_prog_pkg::st_done;
               end else if (fifo_valid) begin
                  next_st.target = fifo_data;
                  next_st.check_pass = 1'b1;
                  next_st.ce_n = 1'b0;
                  next_st.oe_n = 1'b0;
                  next_st.state = eprom_prog_pkg::st_check_read;
               end else begin
                  next_st.timer = st.timer;
               end
            end
         end
         eprom_prog_pkg::st_check_read: begin
            if (st.timer == READ_LAST) begin
               if (!(rd_stable && rd_byte == st.target)) begin
                  next_st.failed = 1'b1;
                  if (st.check_pass) begin
                     next_st.fail_addr = st.addr;
                  end
                  next_st.check_pass = 1'b0;
               end
               next_st.oe_n = 1'b1;
               next_st.state = eprom_prog_pkg::st_check_float;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_check_float: begin
            if (st.timer == FLOAT_LAST) begin
               next_st.timer = '0;
               if (st.addr == LAST_ADDR) begin
                  next_st.ce_n = 1'b1;
                  next_st.state = eprom_prog_pkg::st_done;
               end else if (fifo_valid) begin
                  next_st.addr = st.addr + 1'b1;
                  next_st.target = fifo_data;
                  next_st.oe_n = 1'b0;
                  next_st.state = eprom_prog_pkg::st_check_read;
               end else begin
                  next_st.timer = st.timer;
               end
            end
         end
         eprom_prog_pkg::st_id_read: begin
            if (st.timer == READ_LAST) begin
               if (st.addr[0]) begin
                  next_st.part_code = rd_byte;
               end else begin
                  next_st.maker_code = rd_byte;
               end
               next_st.oe_n = 1'b1;
               next_st.state = eprom_prog_pkg::st_id_float;
               next_st.timer = '0;
            end
         end
         eprom_prog_pkg::st_id_float: begin
            if (st.timer == FLOAT_LAST) begin
               next_st.timer = '0;
               if (!st.addr[0]) begin
                  next_st.addr = {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
                  next_st.oe_n = 1'b0;
                  next_st.state = eprom_prog_pkg::st_id_read;
               end else begin
                  next_st.addr = '0;
                  next_st.ce_n = 1'b1;
                  next_st.id_mode_pin = 1'b0;
                  next_st.state = eprom_prog_pkg::st_done;
               end
            end
         end
         eprom_prog_pkg::st_done: begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            next_st.state = eprom_prog_pkg::st_idle;
         end
         default: begin
            next_st.state = eprom_prog_pkg::st_idle;
         end
      endcase
      // Done is a single-cycle pulse, so it drops again one cycle after idle is reached.
      if (st.state != eprom_prog_pkg::st_done) begin
         next_st.done = 1'b0;
      end
   end

   // State register; pins idle inactive with both supplies at read level.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         st <= '0;
         st.state <= eprom_prog_pkg::st_idle;
         st.ce_n <= 1'b1;
         st.oe_n <= 1'b1;
         st.data_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Every output except src_ready, which comes from the FIFO, is a field of the registered state.
   assign busy = st.busy;
   assign done = st.done;
   assign failed = st.failed;
   assign fail_addr = st.fail_addr;
   assign maker_code = st.maker_code;
   assign part_code = st.part_code;
   assign addr = st.addr;
   assign id_mode_pin = st.id_mode_pin;
   assign chip_enable_n = st.ce_n;
   assign output_enable_n = st.oe_n;
   assign data_out = st.target;
   assign data_oe_n = st.data_oe_n;
   assign vcc_prog = st.vcc_prog;
   assign vpp_prog = st.vpp_prog;
endmodule : eprom_programmer
`default_nettype wire

//--- verification/eprom_programmer_properties.sv
// Concurrent checks on the device pins driven by the EPROM programmer.
// Assumes it is bound to eprom_programmer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_properties #(
   parameter int ADDR_WIDTH = 15,
   parameter int PULSE_CYCLES = 10000,
   parameter int RETRY_LIMIT = 10
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Status and device pins.
   input wire logic done,
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire logic id_mode_pin,
   input wire logic chip_enable_n,
   input wire logic output_enable_n,
   input wire logic data_oe_n,
   input wire logic vcc_prog,
   input wire logic vpp_prog
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   int ce_low;
   int oe_low;
   int pulses;
   logic [ADDR_WIDTH-1:0] prev_addr;
   logic prev_ce_n;
   // Low-time and pulse counters; 32-bit counts never wrap within one pulse.
   always_ff @(posedge sys_clk) begin
      ce_low <= chip_enable_n ? 0 : ce_low + 1;
      oe_low <= output_enable_n ? 0 : oe_low + 1;
      prev_addr <= addr;
      prev_ce_n <= chip_enable_n;
      if (!reset_n || addr != prev_addr) begin
         pulses <= 0;
      end else if (chip_enable_n && !prev_ce_n && vpp_prog) begin
         pulses <= pulses + 1;
      end
   end
   chk_pulse_width: assert property ($rose(chip_enable_n) && vpp_prog |-> ce_low == PULSE_CYCLES)
      else $error("program pulse width wrong");
   chk_first_addr: assert property ($rose(vcc_prog) |-> addr == '0)
      else $error("run did not start at lowest address");
   chk_pulse_supply: assert property (!chip_enable_n && !data_oe_n |-> vcc_prog && vpp_prog)
      else $error("pulse without programming supplies");
   chk_supply_order: assert property (vpp_prog |-> vcc_prog)
      else $error("programming supply without core supply");
   chk_retry_limit: assert property (pulses <= RETRY_LIMIT + 1)
      else $error("too many pulses on one address");
   chk_valid_wait: assert property ($rose(output_enable_n) |-> oe_low >= 15)
      else $error("output enable released before data valid");
   chk_float_wait: assert property ($rose(output_enable_n) |-> data_oe_n [*8])
      else $error("data driven before outputs floated");
   chk_verify_hold: assert property (!output_enable_n && !$past(output_enable_n) |-> $stable(addr))
      else $error("address moved during read");
   chk_no_contention: assert property (!output_enable_n |-> data_oe_n)
      else $error("data driven while outputs enabled");
   chk_id_address: assert property (id_mode_pin |-> addr[ADDR_WIDTH-1:1] == '0 && !vpp_prog)
      else $error("id readout with upper address bits set");
   // Main scenarios: a retry pulse, an id readout and a run ending at nominal supply.
   cover property ($rose(chip_enable_n) && vpp_prog && pulses > 0);
   cover property ($rose(id_mode_pin));
   cover property (done && !vcc_prog);
endmodule : eprom_programmer_properties
`default_nettype wire

//--- verification/eprom_device_model.sv
// Behavioural model of the EPROM on the far side of the programmer.
// Assumes the bench works out no wire level itself: dq is the level seen on the data pins.
`timescale 1ns/1ps
`default_nettype none
module eprom_device_model #(
   parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
   parameter logic [7:0] PART_ID = 8'h3c, // Arbitrary value.
   parameter int VALID_CYCLES = 15
) (
   // Clock and fault controls from the bench.
   input wire logic sys_clk,
   input wire logic erase,
   input wire logic [3:0] slow_addr,
   input wire logic [3:0] slow_pulses,
   input wire logic drift_en,
   // Device pins.
   input wire logic [14:0] addr,
   input wire logic id_mode_pin,
   input wire logic chip_enable_n,
   input wire logic output_enable_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe_n,
   input wire logic vcc_prog,
   input wire logic vpp_prog,
   output logic [7:0] dq
);
   logic [7:0] mem [16];
   int pulses [16];
   int oe_cnt = 0;
   logic [7:0] last = 8'h00;
   logic [7:0] latch = 8'hff;
   logic prev_ce_n = 1'b1;
   logic [7:0] word;
   logic [3:0] a;
   logic [7:0] drift;
   assign a = addr[3:0];
   // A drifting cell reads wrong only at nominal supply, so it slips past verify.
   assign drift = (drift_en && !vpp_prog && a == slow_addr) ? 8'h01 : 8'h00;
   assign word = id_mode_pin ? (addr[0] ? PART_ID : MAKER_ID) : mem[a] ^ drift;
   // Undriven pins show a pattern that flips every cycle, never the last value.
   assign dq = !data_oe_n ? data_out : (oe_cnt >= VALID_CYCLES) ? word : ~last;
   // Programming takes effect at the end of a pulse; the slow cell needs several.
   always @(posedge sys_clk) begin
      last <= dq;
      prev_ce_n <= chip_enable_n;
      oe_cnt <= output_enable_n ? 0 : oe_cnt + 1;
      if (!chip_enable_n && !data_oe_n) latch <= data_out;
      if (erase) begin
         for (int i = 0; i < 16; i++) begin
            mem[i] <= 8'hff;
            pulses[i] <= 0;
         end
      end else if (chip_enable_n && !prev_ce_n && vpp_prog && vcc_prog) begin
         pulses[a] <= pulses[a] + 1;
         if (a != slow_addr || pulses[a] + 1 >= slow_pulses) mem[a] <= mem[a] & latch;
      end
   end
endmodule : eprom_device_model
`default_nettype wire

//--- verification/eprom_rapid_program_sequencer_tb.sv
// Self-checking bench for the EPROM programmer with a device model on its pins.
// Assumes shortened pulse and setup counts and a 16-location array.
`timescale 1ns/1ps
`default_nettype none
module eprom_rapid_program_sequencer_tb;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic start_program = 1'b0;
   logic start_id = 1'b0;
   logic src_valid = 1'b0;
   logic [7:0] src_data = 8'h00;
   logic erase = 1'b1;
   logic [3:0] slow_addr = 4'h0;
   logic [3:0] slow_pulses = 4'h1;
   logic drift_en = 1'b0;
   logic src_ready, busy, done, failed, id_mode_pin, chip_enable_n, output_enable_n, data_oe_n, vcc_prog, vpp_prog;
   logic [14:0] fail_addr, addr;
   logic [7:0] maker_code, part_code, data_out, data_in;
   logic [7:0] q [$];
   int num_errors = 0;
   int num_checks = 0;
   always #5 sys_clk = ~sys_clk;
   eprom_programmer #(.PULSE_CYCLES(20), .SETUP_CYCLES(4), .LAST_ADDR(15'h000f)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .start_program(start_program), .start_id(start_id),
      .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready), .busy(busy), .done(done),
      .failed(failed), .fail_addr(fail_addr), .maker_code(maker_code), .part_code(part_code),
      .addr(addr), .id_mode_pin(id_mode_pin), .chip_enable_n(chip_enable_n),
      .output_enable_n(output_enable_n), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_in(data_in), .vcc_prog(vcc_prog), .vpp_prog(vpp_prog));
   eprom_device_model device (
      .sys_clk(sys_clk), .erase(erase), .slow_addr(slow_addr), .slow_pulses(slow_pulses),
      .drift_en(drift_en), .addr(addr), .id_mode_pin(id_mode_pin), .chip_enable_n(chip_enable_n),
      .output_enable_n(output_enable_n), .data_out(data_out), .data_oe_n(data_oe_n),
      .vcc_prog(vcc_prog), .vpp_prog(vpp_prog), .dq(data_in));
   // Source feeder: shows the queue head and pops it when the FIFO takes it.
   always @(posedge sys_clk) begin
      if (src_valid && src_ready && q.size() > 0) void'(q.pop_front());
      src_valid <= q.size() > 0;
      src_data <= (q.size() > 0) ? q[0] : 8'h00;
   end
   function automatic logic [7:0] img(input int i);
      return 8'h21 + 8'(i * 13);
   endfunction : img
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Reset the design and erase the model; the queue is emptied so no stale bytes leak.
   task automatic reset_all(input logic [3:0] sa, input logic [3:0] sp, input logic de);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      erase <= 1'b1;
      slow_addr <= sa;
      slow_pulses <= sp;
      drift_en <= de;
      q.delete();
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      erase <= 1'b0;
   endtask : reset_all
   task automatic load_image();
      for (int i = 0; i < 16; i++) q.push_back(img(i));
   endtask : load_image
   task automatic run_cmd(input logic id);
      int n;
      @(posedge sys_clk);
      if (id) start_id <= 1'b1;
      else start_program <= 1'b1;
      @(posedge sys_clk);
      start_id <= 1'b0;
      start_program <= 1'b0;
      n = 0;
      #1;
      check("busy", busy, 1'b1);
      while (done !== 1'b1 && n < 20000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check("done", done, 1'b1);
      check("busy at done", busy, 1'b0);
      @(posedge sys_clk);
      #1;
      check("done pulse", done, 1'b0);
   endtask : run_cmd
   task automatic test_program_pass();
      reset_all(4'h5, 4'h4, 1'b0);
      load_image();
      load_image();
      repeat (24) @(posedge sys_clk);
      #1;
      check("src_ready when full", src_ready, 1'b0);
      check("src_valid held", src_valid, 1'b1);
      run_cmd(1'b0);
      check("failed", failed, 1'b0);
      check("queue drained", q.size(), 0);
      for (int i = 0; i < 16; i++) check("cell", device.mem[i], img(i));
      check("first cell pulses", device.pulses[0], 1);
      check("slow cell pulses", device.pulses[5], 4);
      check("supplies nominal", {vcc_prog, vpp_prog}, 2'b00);
      $display("test_program_pass finished");
   endtask : test_program_pass
   task automatic test_retry_abort();
      reset_all(4'h2, 4'hc, 1'b0);
      load_image();
      load_image();
      run_cmd(1'b0);
      check("failed", failed, 1'b1);
      check("fail_addr", fail_addr, 15'h0002);
      check("stuck cell pulses", device.pulses[2], 11);
      check("next cell pulses", device.pulses[3], 0);
      check("vpp off", vpp_prog, 1'b0);
      $display("test_retry_abort finished");
   endtask : test_retry_abort
   task automatic test_check_fail();
      reset_all(4'h7, 4'h1, 1'b1);
      load_image();
      load_image();
      run_cmd(1'b0);
      check("failed", failed, 1'b1);
      check("fail_addr", fail_addr, 15'h0007);
      check("drift cell", device.mem[7], img(7));
      check("last cell", device.mem[15], img(15));
      $display("test_check_fail finished");
   endtask : test_check_fail
   task automatic test_id_read();
      reset_all(4'h0, 4'h1, 1'b0);
      run_cmd(1'b1);
      check("maker_code", maker_code, 8'h5a);
      check("part_code", part_code, 8'h3c);
      check("id pin off", id_mode_pin, 1'b0);
      $display("test_id_read finished");
   endtask : test_id_read
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // Watchdog: the four runs take about a tenth of this span.
   initial begin
      #400_000;
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      test_program_pass();
      test_retry_abort();
      test_check_fail();
      test_id_read();
      complete_run();
   end
endmodule : eprom_rapid_program_sequencer_tb
bind eprom_programmer eprom_programmer_properties #(
   .ADDR_WIDTH(ADDR_WIDTH), .PULSE_CYCLES(PULSE_CYCLES), .RETRY_LIMIT(RETRY_LIMIT)) checker_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .done(done), .addr(addr), .id_mode_pin(id_mode_pin),
   .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .data_oe_n(data_oe_n),
   .vcc_prog(vcc_prog), .vpp_prog(vpp_prog));
`default_nettype wire
